// ### hw/sbt_timer.sv
// split byte event timer: counter pair, control/status and output pin
// Overview of operation
// - output pin follows written output-level bit; reset low
// - clock select codes 100..111 choose clk/32, clk/16, clk/4, watch/4
// - code 000 counts event pin edges, polarity from edge-select input
// - a spurious count may occur when the event pin function is enabled
// - control/status register is 8 bits, read/write, reset to zero
// - flag bits 7,6,3,2 accept only a written zero; ones ignored
// - high overflow flag sets when high counter rolls from ff to 00
// - high overflow flag clears only by write 0 after reading it as 1
// - high match flag sets on high match (16-bit match in joined mode); clears by read 1, write 0
// - bit 5 enables the high overflow interrupt request
// - joined mode: bit 4 clears whole 16-bit counter on 16-bit match
// - split mode: bit 4 clears high counter on high compare match
// - low overflow flag sets when low counter rolls ff to 00
// - low overflow flag clears only by write 0 after reading it as 1
`timescale 1ns/1ns
module sbt_timer (
   // clock and reset
   input  wire logic                  core_clk_i,
   input  wire logic                  rst_i,
   // control/status register access
   input  wire sbt_pkg::sbt_bus_s     csr_bus_i,
   output logic [7:0]                 csr_rdata_o,
   // configuration
   input  wire logic [2:0]            clk_sel_i,
   input  wire logic                  out_level_wr_i,
   input  wire logic                  out_level_i,
   input  wire logic                  joined_mode_i,
   input  wire logic [15:0]           joined_compare_value_i,
   input  wire logic                  event_edge_select_i,
   input  wire logic                  event_pin_function_bit_i,
   // count sources
   input  wire logic                  watch_tick_i,
   input  wire logic                  event_input_pin_i,
   // outputs
   output logic                       low_timer_output_pin_o,
   output logic [15:0]                joined_counter_o,
   output logic                       high_overflow_irq_o,
   output logic                       low_overflow_irq_o
);
   logic [7:0]  csr_reg;
   logic [7:0]  low_byte_counter_reg;
   logic [7:0]  high_byte_counter_reg;
   logic [7:0]  seen_one_reg;
   logic [4:0]  div_reg;
   logic [1:0]  watch_div_reg;
   logic        ev_prev_reg;
   logic        low_tick;
   logic        ev_edge;
   logic        high_tick;
   logic        low_match;
   logic        high_match;
   logic        joined_match;
   logic        low_clr;
   logic        high_clr;
   logic        low_ovf;
   logic        high_ovf;
   logic [7:0]  flag_set;
   logic [7:0]  flag_clr;

   // free-running prescaler; watch clock divided by four on its ticks
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         div_reg       <= '0;
         watch_div_reg <= '0;
      end else begin
         div_reg <= div_reg + 5'd1;
         if (watch_tick_i)
            watch_div_reg <= watch_div_reg + 2'd1;
      end
   end

   // edge detect only while the pin function is on; enabling it while
   // the pin sits low can yield one extra count
   always_ff @(posedge core_clk_i) begin
      if (rst_i)
         ev_prev_reg <= 1'b1;
      else if (!event_pin_function_bit_i)
         ev_prev_reg <= 1'b1;
      else
         ev_prev_reg <= event_input_pin_i;
   end

   assign ev_edge = event_pin_function_bit_i &&
      (event_edge_select_i ? (event_input_pin_i && !ev_prev_reg)
                           : (!event_input_pin_i && ev_prev_reg));

   always_comb begin
      case (sbt_pkg::sbt_src_e'(clk_sel_i))
         sbt_pkg::SBT_SRC_EVENT: low_tick = ev_edge;
         sbt_pkg::SBT_SRC_DIV32:
            low_tick = (int'(div_reg) % sbt_pkg::DIV32 == sbt_pkg::DIV32 - 1);
         sbt_pkg::SBT_SRC_DIV16:
            low_tick = (int'(div_reg) % sbt_pkg::DIV16 == sbt_pkg::DIV16 - 1);
         sbt_pkg::SBT_SRC_DIV4:
            low_tick = (int'(div_reg) % sbt_pkg::DIV4 == sbt_pkg::DIV4 - 1);
         sbt_pkg::SBT_SRC_WDIV4:
            low_tick = watch_tick_i &&
                       (int'(watch_div_reg) == sbt_pkg::DIV4 - 1);
         // prohibited and unused codes hold the count
         default: low_tick = 1'b0;
      endcase
   end

   assign joined_match = ({high_byte_counter_reg, low_byte_counter_reg}
                          == joined_compare_value_i);
   assign low_match  = (low_byte_counter_reg ==
                        joined_compare_value_i[7:0]);
   assign high_match = (high_byte_counter_reg ==
                        joined_compare_value_i[15:8]);
   assign low_ovf    = low_tick && (low_byte_counter_reg ==
                        sbt_pkg::BYTE_ALL_ONES);
   // joined mode carries from low byte; split mode has no high source,
   // so the high byte counts the same ticks
   assign high_tick  = joined_mode_i ? low_ovf : low_tick;
   assign high_ovf   = high_tick && (high_byte_counter_reg ==
                        sbt_pkg::BYTE_ALL_ONES);
   assign high_clr = csr_reg[sbt_pkg::BIT_HI_CLR_EN] &&
      (joined_mode_i ? joined_match : high_match);
   assign low_clr = joined_mode_i ? high_clr
      : (csr_reg[sbt_pkg::BIT_LO_CLR_EN] && low_match);

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         low_byte_counter_reg  <= sbt_pkg::BYTE_ZERO;
         high_byte_counter_reg <= sbt_pkg::BYTE_ZERO;
      end else begin
         if (low_clr)
            low_byte_counter_reg <= sbt_pkg::BYTE_ZERO;
         else if (low_tick)
            low_byte_counter_reg <= low_byte_counter_reg + 8'h01;
         if (high_clr)
            high_byte_counter_reg <= sbt_pkg::BYTE_ZERO;
         else if (high_tick)
            high_byte_counter_reg <= high_byte_counter_reg + 8'h01;
      end
   end

   always_comb begin
      flag_set = sbt_pkg::BYTE_ZERO;
      flag_set[sbt_pkg::BIT_HI_OVF] = high_ovf;
      flag_set[sbt_pkg::BIT_HI_MATCH] = joined_mode_i ? joined_match
                                                      : high_match;
      flag_set[sbt_pkg::BIT_LO_OVF] = low_ovf;
      flag_set[sbt_pkg::BIT_LO_MATCH] = low_match;
   end

   // clear needs a prior read of 1, and a set in the same cycle wins
   assign flag_clr = (csr_bus_i.wr ? ~csr_bus_i.wdata : sbt_pkg::BYTE_ZERO)
                     & seen_one_reg & sbt_pkg::FLAG_MASK;

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         csr_reg      <= sbt_pkg::CSR_RESET;
         seen_one_reg <= sbt_pkg::BYTE_ZERO;
      end else begin
         // writes of 1 to flags are dropped
         csr_reg <= (csr_bus_i.wr
            ? ((csr_bus_i.wdata & ~sbt_pkg::FLAG_MASK)
               | (csr_reg & sbt_pkg::FLAG_MASK))
            : csr_reg) & ~flag_clr | flag_set;
         if (csr_bus_i.rd)
            seen_one_reg <= csr_reg & sbt_pkg::FLAG_MASK;
         else if (csr_bus_i.wr)
            seen_one_reg <= sbt_pkg::BYTE_ZERO;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         csr_rdata_o            <= sbt_pkg::CSR_RESET;
         low_timer_output_pin_o <= 1'b0;
         joined_counter_o       <= sbt_pkg::WORD_ZERO;
         high_overflow_irq_o    <= 1'b0;
         low_overflow_irq_o     <= 1'b0;
      end else begin
         csr_rdata_o <= csr_reg;
         if (out_level_wr_i)
            low_timer_output_pin_o <= out_level_i;
         joined_counter_o <= {high_byte_counter_reg, low_byte_counter_reg};
         high_overflow_irq_o <= csr_reg[sbt_pkg::BIT_HI_OVF] &&
                                csr_reg[sbt_pkg::BIT_HI_OVF_IE];
         low_overflow_irq_o  <= csr_reg[sbt_pkg::BIT_LO_OVF] &&
                                csr_reg[sbt_pkg::BIT_LO_OVF_IE];
      end
   end

   AST_PIN_LEVEL: assert property (@(posedge core_clk_i) disable iff (rst_i)
      out_level_wr_i |=> low_timer_output_pin_o == $past(out_level_i))
      else $error("output pin did not take written level");
   AST_DIV4: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (clk_sel_i == sbt_pkg::SBT_SRC_DIV4 && low_tick) |=>
      (!low_tick || clk_sel_i != sbt_pkg::SBT_SRC_DIV4) [*3] ##1
      (low_tick || clk_sel_i != sbt_pkg::SBT_SRC_DIV4))
      else $error("divide by four tick spacing wrong");
   AST_BAN_HOLD: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (clk_sel_i == sbt_pkg::SBT_SRC_BAN && !low_clr) |=>
      low_byte_counter_reg == $past(low_byte_counter_reg))
      else $error("counter moved on prohibited source");
   AST_EV_RISE: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (clk_sel_i == 3'h0 && event_edge_select_i && event_pin_function_bit_i
       && event_input_pin_i && !ev_prev_reg) |-> low_tick)
      else $error("rising edge not counted");
   AST_FLAG_NOSET: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (!csr_reg[sbt_pkg::BIT_HI_OVF] && !high_ovf) |=>
      !csr_reg[sbt_pkg::BIT_HI_OVF])
      else $error("overflow flag set without overflow");
   AST_HIGH_OVERFLOW_FLAG_SET: assert property (@(posedge core_clk_i) disable iff (rst_i)
      high_ovf |=> csr_reg[sbt_pkg::BIT_HI_OVF])
      else $error("high overflow flag not set");
   AST_HIGH_OVERFLOW_FLAG_CLR: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (csr_reg[sbt_pkg::BIT_HI_OVF] && !(csr_bus_i.wr &&
       seen_one_reg[sbt_pkg::BIT_HI_OVF])) |=> csr_reg[sbt_pkg::BIT_HI_OVF])
      else $error("high overflow flag cleared without read");
   AST_LOW_OVERFLOW_FLAG_SET: assert property (@(posedge core_clk_i) disable iff (rst_i)
      low_ovf |=> csr_reg[sbt_pkg::BIT_LO_OVF] ##1
      (low_overflow_irq_o == $past(csr_reg[sbt_pkg::BIT_LO_OVF_IE])))
      else $error("low overflow flag or request wrong");
   AST_HCLR: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (joined_mode_i && csr_reg[sbt_pkg::BIT_HI_CLR_EN] && joined_match) |=>
      ({high_byte_counter_reg, low_byte_counter_reg} == sbt_pkg::WORD_ZERO)
      ##1 (joined_counter_o == sbt_pkg::WORD_ZERO))
      else $error("joined clear on match failed");
endmodule : sbt_timer

// ### hw/sbt_pkg.sv
// package for the split byte event timer
package sbt_pkg;
   localparam int          DATA_W          = 8;
   localparam logic [7:0]  CSR_RESET       = 8'h00;
   localparam logic [7:0]  BYTE_ALL_ONES   = 8'hff;
   localparam logic [7:0]  BYTE_ZERO       = 8'h00;
   localparam logic [15:0] WORD_ZERO       = 16'h0000;
   // csr field positions
   localparam int          BIT_HI_OVF      = 7;
   localparam int          BIT_HI_MATCH    = 6;
   localparam int          BIT_HI_OVF_IE   = 5;
   localparam int          BIT_HI_CLR_EN   = 4;
   localparam int          BIT_LO_OVF      = 3;
   localparam int          BIT_LO_MATCH    = 2;
   localparam int          BIT_LO_OVF_IE   = 1;
   localparam int          BIT_LO_CLR_EN   = 0;
   localparam logic [7:0]  FLAG_MASK       = 8'hcc;
   // prescale divide counts
   localparam int          DIV32           = 32;
   localparam int          DIV16           = 16;
   localparam int          DIV4            = 4;
   localparam int          DIV_W           = 5;

   typedef enum logic [2:0] {
      SBT_SRC_EVENT = 3'h0,
      SBT_SRC_RSV1  = 3'h1,
      SBT_SRC_RSV2  = 3'h2,
      SBT_SRC_BAN   = 3'h3,
      SBT_SRC_DIV32 = 3'h4,
      SBT_SRC_DIV16 = 3'h5,
      SBT_SRC_DIV4  = 3'h6,
      SBT_SRC_WDIV4 = 3'h7
   } sbt_src_e;

   // byte-wide register access strobe bundle
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] wdata;
   } sbt_bus_s;
endpackage : sbt_pkg

// ### sim/sbt_event_src.sv
// event pin source model for the split byte event timer
`timescale 1ns/1ns
module sbt_event_src (
   // clock
   input  wire logic core_clk_i,
   // event pin
   output logic      event_input_pin_o
);
   // idles high like a pulled-up pin, so enabling the pin
   // function never sees a low level and takes no stray count
   initial event_input_pin_o = 1'b1;

   // each pulse is low for three cycles, then high for four
   task automatic burst(input int n);
      repeat (n) begin
         @(negedge core_clk_i) event_input_pin_o = 1'b0;
         repeat (3) @(negedge core_clk_i);
         event_input_pin_o = 1'b1;
         repeat (3) @(negedge core_clk_i);
      end
   endtask : burst
endmodule : sbt_event_src

// ### sim/split_byte_event_timer_bench.sv
// self-checking bench for the split byte event timer
`timescale 1ns/1ns
module split_byte_event_timer_bench;
   logic              core_clk_i = 1'b0;
   logic              rst_i      = 1'b1;
   sbt_pkg::sbt_bus_s bus        = '0;
   logic [2:0]        sel        = 3'h1;
   logic              owr = 1'b0, olv = 1'b0, jm_r = 1'b0;
   logic              esel = 1'b1, pfn = 1'b0, wtick = 1'b0;
   logic [15:0]       cmp = 16'hffff;
   logic [7:0]        rdata;
   logic [15:0]       cnt;
   logic              pin, pin_o, irq_h, irq_l;
   int                err_total = 0, cmp_count = 0, cyc = 0;

   always #10 core_clk_i = ~core_clk_i;
   always @(negedge core_clk_i) wtick <= ~wtick;

   sbt_timer i_sbt_timer (.core_clk_i(core_clk_i), .rst_i(rst_i),
      .csr_bus_i(bus), .csr_rdata_o(rdata), .clk_sel_i(sel),
      .out_level_wr_i(owr), .out_level_i(olv), .joined_mode_i(jm_r),
      .joined_compare_value_i(cmp), .event_edge_select_i(esel),
      .event_pin_function_bit_i(pfn), .watch_tick_i(wtick),
      .event_input_pin_i(pin), .low_timer_output_pin_o(pin_o),
      .joined_counter_o(cnt), .high_overflow_irq_o(irq_h),
      .low_overflow_irq_o(irq_l));
   sbt_event_src i_sbt_event_src (.core_clk_i(core_clk_i),
      .event_input_pin_o(pin));

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : tally_and_finish

   // run is far shorter than this ceiling
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         tally_and_finish();
      end
   end

   task automatic chk(input string nm, input logic [15:0] s, e);
      cmp_count++;
      if (s !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   // one access, then a settle cycle so the register copy is current
   task automatic acc(input logic r, input logic [7:0] d);
      @(negedge core_clk_i) bus = '{rd: r, wr: !r, wdata: d};
      @(negedge core_clk_i) bus = '0;
      @(negedge core_clk_i);
   endtask : acc

   task automatic t_basic();
      chk("csr", rdata, 16'h0000);
      chk("cnt", cnt, 16'h0000);
      chk("pin", pin_o, 16'h0000);
      for (int v = 1; v >= 0; v--) begin
         @(negedge core_clk_i) owr = 1'b1;
         olv = v[0];
         @(negedge core_clk_i) owr = 1'b0;
         chk("pin", pin_o, v[15:0]);
      end
      acc(1'b0, 8'hff);
      chk("csr", rdata, 16'h0033);
      acc(1'b0, 8'h00);
      chk("csr", rdata, 16'h0000);
      $display("test basic done");
   endtask : t_basic

   task automatic t_event();
      pfn = 1'b1;
      sel = 3'h0;
      i_sbt_event_src.burst(5);
      repeat (4) @(negedge core_clk_i);
      chk("evt rise", cnt[7:0], 16'h0005);
      esel = 1'b0;
      i_sbt_event_src.burst(5);
      repeat (4) @(negedge core_clk_i);
      chk("evt fall", cnt[7:0], 16'h000a);
      sel = 3'h1;
      $display("test event done");
   endtask : t_event

   task automatic t_rate();
      int         dv [4] = '{32, 16, 4, 8};
      logic [7:0] c0, d;
      for (int i = 0; i < 4; i++) begin
         c0 = cnt[7:0];
         @(negedge core_clk_i) sel = 3'h4 + i[2:0];
         repeat (8 * dv[i]) @(negedge core_clk_i);
         sel = 3'h1;
         repeat (3) @(negedge core_clk_i);
         d = cnt[7:0] - c0;
         chk("rate", 16'(d), 16'h0008);
      end
      c0 = cnt[7:0];
      sel = 3'h3;
      repeat (40) @(negedge core_clk_i);
      chk("hold", cnt[7:0], 16'(c0));
      sel = 3'h1;
      $display("test rate done");
   endtask : t_rate

   task automatic t_flags();
      cmp = 16'h0505;
      acc(1'b0, 8'h22);
      sel = 3'h6;
      repeat (1100) @(negedge core_clk_i);
      sel = 3'h1;
      repeat (3) @(negedge core_clk_i);
      chk("csr", rdata, 16'h00ee);
      chk("irq", {irq_h, irq_l}, 16'h0003);
      acc(1'b0, 8'h22);
      chk("csr", rdata, 16'h00ee);
      acc(1'b1, 8'h00);
      acc(1'b0, 8'h22);
      chk("csr", rdata, 16'h0022);
      chk("irq", {irq_h, irq_l}, 16'h0000);
      $display("test flags done");
   endtask : t_flags

   task automatic t_clr(input logic jm, input logic [15:0] c, input int w);
      logic ok;
      jm_r = jm;
      cmp = c;
      acc(1'b0, 8'h11);
      sel = 3'h6;
      repeat (w) @(negedge core_clk_i);
      for (int i = 0; i < 100; i++) begin
         @(negedge core_clk_i);
         ok = jm ? cnt <= c : cnt[15:8] <= c[15:8] && cnt[7:0] <= c[7:0];
         chk("clear", 16'(ok), 16'h0001);
      end
      sel = 3'h1;
      $display("test clear done");
   endtask : t_clr

   initial begin
      repeat (4) @(posedge core_clk_i);
      @(negedge core_clk_i) rst_i = 1'b0;
      t_basic();
      t_event();
      t_rate();
      t_flags();
      t_clr(1'b0, 16'h0303, 1200);
      t_clr(1'b1, 16'h0404, 4200);
      tally_and_finish();
   end
endmodule : split_byte_event_timer_bench
